// file: hw/quad_status_regs.vh
// Register offsets, field positions and reset values of the quadrature status block.
// Included by the status block design file only, not by the phase decoder; defines only.
`ifndef QUAD_STATUS_REGS_VH
`define QUAD_STATUS_REGS_VH

`define OFS_CAPTURE_AB 8'h8c
`define OFS_COUNTER_VALUE 8'h90
`define OFS_COMPARE_A 8'h94
`define OFS_COMPARE_B 8'h98
`define OFS_COMPARE_C 8'h9c
`define OFS_EVENT_STATUS 8'ha0
`define OFS_IRQ_ENABLE 8'ha4
`define OFS_IRQ_DISABLE 8'ha8
`define OFS_IRQ_MASK 8'hac
`define OFS_EXTENDED_MODE 8'hb0
`define OFS_SYNC_CONTROL 8'hc0
`define OFS_DECODER_FLAGS 8'hd4
`define OFS_PULSE_LIMIT 8'he0

`define BIT_INDEX 0
`define BIT_REVERSAL 1
`define BIT_PHASE_FAULT 2
`define BIT_MISSING_PULSE 3
`define BIT_DIRECTION 8

`define RST_DECODER_FLAGS 32'h00000000
`define RST_PULSE_LIMIT 8'h08
`define PULSE_GAP_CYCLES 16'h0100

`endif

// file: hw/quad_phase_decoder.v
// Quadrature phase decoder: direction, count pulses and event pulses.
// Assumes phase and index inputs are already synchronised to mclk_in.
`default_nettype none
module quad_phase_decoder #(
   parameter LIMIT_W = 8,
   parameter GAP_W = 16
) (
   // Clock and reset
   input wire mclk_in,
   input wire rst_in,
   // Synchronised encoder signals
   input wire pha_in,
   input wire phb_in,
   input wire idx_in,
   // Configuration
   input wire [LIMIT_W-1:0] missing_pulse_limit_in,
   input wire [GAP_W-1:0] gap_cycles_in,
   // Results
   output reg direction_out,
   output reg step_out,
   output reg reversal_out,
   output reg phase_fault_out,
   output reg missing_pulse_out,
   output reg index_out
);
   reg [1:0] prev_ff;
   reg idx_prev_ff;
   reg [GAP_W-1:0] gap_cnt_ff;
   reg [LIMIT_W-1:0] miss_cnt_ff;
   reg valid_step;
   reg step_dir;
   reg bad_step;
   wire [1:0] cur = {pha_in, phb_in};

   // Gray transition table: forward 00-01-11-10
   always @* begin
      valid_step = 1'b0;
      step_dir = 1'b0;
      bad_step = 1'b0;
      case ({prev_ff, cur})
         4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            valid_step = 1'b1;
            step_dir = 1'b0;
         end
         4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            valid_step = 1'b1;
            step_dir = 1'b1;
         end
         4'b0011, 4'b1100, 4'b0110, 4'b1001: bad_step = 1'b1;
         default: bad_step = 1'b0;
      endcase
   end

   always @(posedge mclk_in) begin
      if (rst_in) begin
         prev_ff <= 2'b00;
         idx_prev_ff <= 1'b0;
         gap_cnt_ff <= {GAP_W{1'b0}};
         miss_cnt_ff <= {LIMIT_W{1'b0}};
         direction_out <= 1'b0;
         step_out <= 1'b0;
         reversal_out <= 1'b0;
         phase_fault_out <= 1'b0;
         missing_pulse_out <= 1'b0;
         index_out <= 1'b0;
      end else begin
         prev_ff <= cur;
         idx_prev_ff <= idx_in;
         step_out <= valid_step;
         index_out <= idx_in & ~idx_prev_ff;
         phase_fault_out <= bad_step;
         reversal_out <= valid_step & (step_dir != direction_out);
         missing_pulse_out <= 1'b0;
         if (valid_step) begin
            direction_out <= step_dir;
         end
         // Missing pulse: no edge for a gap period counts one miss
         if (valid_step) begin
            gap_cnt_ff <= {GAP_W{1'b0}};
            miss_cnt_ff <= {LIMIT_W{1'b0}};
         end else if (gap_cnt_ff == gap_cycles_in) begin
            gap_cnt_ff <= {GAP_W{1'b0}};
            if (miss_cnt_ff + 1'b1 >= missing_pulse_limit_in && missing_pulse_limit_in != {LIMIT_W{1'b0}}) begin
               missing_pulse_out <= 1'b1;
               miss_cnt_ff <= {LIMIT_W{1'b0}};
            end else begin
               miss_cnt_ff <= miss_cnt_ff + 1'b1;
            end
         end else begin
            gap_cnt_ff <= gap_cnt_ff + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/timer_quadrature_status.v
// Quadrature status block with channel 2 register window, APB slave.
// Encoder pins are asynchronous; APB runs on mclk_in.
//
// The APB register port was decided locally.
`include "quad_status_regs.vh"
`default_nettype none
// Functional notes
// RULE1: Bit 8 shows live rotation direction
// RULE2: Bit 3 sticky missing-pulse fault until read
// RULE3: Bit 2 sticky phase-sequence fault until read
// RULE4: Bit 1 sticky reversal flag until read
// RULE5: Flags at 0xd4, read-only, reset zero, read-clears
// RULE6: Event in read cycle survives the clear
module timer_quadrature_status #(
   parameter LIMIT_W = 8,
   parameter GAP_W = 16
) (
   // Clock and reset
   input wire mclk_in,
   input wire rst_in,
   // APB slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire pready_out,
   output wire pslverr_out,
   output reg [31:0] prdata_out,
   // Encoder pins
   input wire pha_in,
   input wire phb_in,
   input wire idx_in,
   // Status
   output wire direction_out,
   output wire [31:0] counter_out
);
   reg [2:0] sync1_ff;
   reg [2:0] sync2_ff;
   reg [31:0] counter_ff;
   reg [31:0] cmp_a_ff;
   reg [31:0] cmp_b_ff;
   reg [31:0] cmp_c_ff;
   reg [31:0] ext_mode_ff;
   reg [7:0] irq_mask_ff;
   reg [LIMIT_W-1:0] missing_pulse_limit_ff;
   reg index_pulse_flag_ff;
   reg rotation_reversal_flag_ff;
   reg phase_sequence_fault_ff;
   reg missing_pulse_fault_ff;
   reg [31:0] nxt_rdata;
   reg addr_ok;
   wire dir;
   wire step;
   wire rev_ev;
   wire fault_ev;
   wire miss_ev;
   wire idx_ev;
   wire access = psel_in & penable_in;
   wire wr = access & pwrite_in;
   wire rd_flags = access & ~pwrite_in & (paddr_in == `OFS_DECODER_FLAGS);
   // Only flags already returned in prdata may be cleared by this read
   wire [3:0] clr_flags = {4{rd_flags}} & prdata_out[3:0];

   // Two-stage synchronisers on encoder pins
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
      end else begin
         sync1_ff <= {pha_in, phb_in, idx_in};
         sync2_ff <= sync1_ff;
      end
   end

   quad_phase_decoder #(
      .LIMIT_W(LIMIT_W),
      .GAP_W(GAP_W)
   ) u_dec (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .pha_in(sync2_ff[2]),
      .phb_in(sync2_ff[1]),
      .idx_in(sync2_ff[0]),
      .missing_pulse_limit_in(missing_pulse_limit_ff),
      .gap_cycles_in(`PULSE_GAP_CYCLES),
      .direction_out(dir),
      .step_out(step),
      .reversal_out(rev_ev),
      .phase_fault_out(fault_ev),
      .missing_pulse_out(miss_ev),
      .index_out(idx_ev)
   );

   assign direction_out = dir;
   assign counter_out = counter_ff;
   assign pready_out = 1'b1;
   assign pslverr_out = access & ~addr_ok;

   // Sticky flags: set wins; an event after the setup edge survives the read
   always @(posedge mclk_in) begin
      if (rst_in) begin
         index_pulse_flag_ff <= 1'b0;
         rotation_reversal_flag_ff <= 1'b0;
         phase_sequence_fault_ff <= 1'b0;
         missing_pulse_fault_ff <= 1'b0;
      end else begin
         index_pulse_flag_ff <= idx_ev
            | (index_pulse_flag_ff & ~clr_flags[`BIT_INDEX]); // [RULE5] [RULE6]
         rotation_reversal_flag_ff <= rev_ev
            | (rotation_reversal_flag_ff & ~clr_flags[`BIT_REVERSAL]); // [RULE4] [RULE6]
         phase_sequence_fault_ff <= fault_ev
            | (phase_sequence_fault_ff & ~clr_flags[`BIT_PHASE_FAULT]); // [RULE3] [RULE6]
         missing_pulse_fault_ff <= miss_ev
            | (missing_pulse_fault_ff & ~clr_flags[`BIT_MISSING_PULSE]); // [RULE2] [RULE6]
      end
   end

   // Counter and writable registers
   always @(posedge mclk_in) begin
      if (rst_in) begin
         counter_ff <= 32'h00000000;
         cmp_a_ff <= 32'h00000000;
         cmp_b_ff <= 32'h00000000;
         cmp_c_ff <= 32'h00000000;
         ext_mode_ff <= 32'h00000000;
         irq_mask_ff <= 8'h00;
         missing_pulse_limit_ff <= `RST_PULSE_LIMIT;
      end else begin
         if (wr && paddr_in == `OFS_SYNC_CONTROL && pwdata_in[0]) begin
            counter_ff <= 32'h00000000;
         end else if (step) begin
            counter_ff <= dir ? counter_ff - 32'h00000001 : counter_ff + 32'h00000001;
         end
         if (wr) begin
            case (paddr_in)
               `OFS_COMPARE_A: cmp_a_ff <= pwdata_in;
               `OFS_COMPARE_B: cmp_b_ff <= pwdata_in;
               `OFS_COMPARE_C: cmp_c_ff <= pwdata_in;
               `OFS_EXTENDED_MODE: ext_mode_ff <= pwdata_in;
               `OFS_IRQ_ENABLE: irq_mask_ff <= irq_mask_ff | pwdata_in[7:0];
               `OFS_IRQ_DISABLE: irq_mask_ff <= irq_mask_ff & ~pwdata_in[7:0];
               `OFS_PULSE_LIMIT: missing_pulse_limit_ff <= pwdata_in[LIMIT_W-1:0];
               default: irq_mask_ff <= irq_mask_ff;
            endcase
         end
      end
   end

   // Address decode and read mux
   always @* begin
      addr_ok = 1'b1;
      nxt_rdata = 32'h00000000;
      case (paddr_in)
         `OFS_CAPTURE_AB: nxt_rdata = cmp_a_ff;
         `OFS_COUNTER_VALUE: nxt_rdata = counter_ff;
         `OFS_COMPARE_A: nxt_rdata = cmp_a_ff;
         `OFS_COMPARE_B: nxt_rdata = cmp_b_ff;
         `OFS_COMPARE_C: nxt_rdata = cmp_c_ff;
         `OFS_EVENT_STATUS: nxt_rdata = 32'h00000000;
         `OFS_IRQ_ENABLE: nxt_rdata = 32'h00000000;
         `OFS_IRQ_DISABLE: nxt_rdata = 32'h00000000;
         `OFS_IRQ_MASK: nxt_rdata = {24'h000000, irq_mask_ff};
         `OFS_EXTENDED_MODE: nxt_rdata = ext_mode_ff;
         `OFS_SYNC_CONTROL: nxt_rdata = 32'h00000000;
         `OFS_DECODER_FLAGS: begin
            nxt_rdata = `RST_DECODER_FLAGS; // [RULE5]
            nxt_rdata[`BIT_DIRECTION] = dir; // [RULE1]
            nxt_rdata[`BIT_MISSING_PULSE] = missing_pulse_fault_ff; // [RULE2]
            nxt_rdata[`BIT_PHASE_FAULT] = phase_sequence_fault_ff; // [RULE3]
            nxt_rdata[`BIT_REVERSAL] = rotation_reversal_flag_ff; // [RULE4]
            nxt_rdata[`BIT_INDEX] = index_pulse_flag_ff;
         end
         `OFS_PULSE_LIMIT: nxt_rdata = {{(32-LIMIT_W){1'b0}}, missing_pulse_limit_ff};
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data registered in the setup cycle, valid in the access phase
   always @(posedge mclk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h00000000;
      end else if (psel_in & ~penable_in & ~pwrite_in) begin
         prdata_out <= nxt_rdata;
      end
   end
endmodule
`default_nettype wire

// file: bench/quad_encoder_model.sv
// Behavioural rotary encoder driving the two phase pins and the index pin.
// Moves are called from the bench; pins change just after a clock edge.
`default_nettype none
module quad_encoder_model (
   input wire logic clk_in,
   output logic pha_out,
   output logic phb_out,
   output logic idx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pos_ff = 2'h0;
   // Gray order 00,01,11,10; a step of 2 moves both phases at once
   assign pha_out = pos_ff[1];
   assign phb_out = pos_ff[1] ^ pos_ff[0];
   logic idx_ff = 1'b0;
   assign idx_out = idx_ff;
   task pulse_index;
      @(posedge clk_in);
      idx_ff <= 1'b1;
      @(posedge clk_in);
      idx_ff <= 1'b0;
   endtask
   task move(input logic [1:0] d);
      @(posedge clk_in);
      pos_ff <= pos_ff + d;
   endtask
endmodule
`default_nettype wire

// file: bench/timer_quadrature_status_properties.sv
// Port checker for the quadrature status block.
// Bound to every instance of the block; watches APB and status ports.
`default_nettype none
module timer_quadrature_status_checker (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [31:0] prdata_out,
   input wire logic direction_out,
   input wire logic [31:0] counter_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire rd_flags = psel_in && penable_in && !pwrite_in && paddr_in == 8'hd4;
   a_ready_high: assert property (pready_out) else $error("pready low");
   a_dir_live: assert property (rd_flags |-> prdata_out[8] == $past(direction_out))
      else $error("direction bit not live");
   a_reserved_zero: assert property (rd_flags |-> prdata_out[31:9] == 23'h0 && prdata_out[7:4] == 4'h0)
      else $error("reserved flag bits set");
   a_reset_clear: assert property ($past(rst_in) |->
      prdata_out == 32'h0 && counter_out == 32'h0 && !direction_out)
      else $error("outputs not cleared by reset");
   a_flags_mapped: assert property (rd_flags |-> !pslverr_out) else $error("flags read refused");
   a_err_access: assert property (pslverr_out |-> psel_in && penable_in) else $error("error outside access");
   a_unmapped_err: assert property (psel_in && penable_in && paddr_in == 8'h50 |->
      pslverr_out && (pwrite_in || prdata_out == 32'h0)) else $error("unmapped access accepted");
endmodule
bind timer_quadrature_status timer_quadrature_status_checker chk (.mclk_in(mclk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
   .direction_out(direction_out), .counter_out(counter_out));
`default_nettype wire

// file: bench/tb_timer_quadrature_status.sv
// Self-checking bench for the quadrature status block.
// Drives APB as master and the encoder model as far side.
`default_nettype none
module tb_timer_quadrature_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dir_exp = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, r1, r2;
   wire pready, pslverr, dir, pha, phb, idx;
   wire [31:0] prdata, count;
   int fail_count = 0, tests_run = 0;
   always #25 mclk_in = ~mclk_in;
   timer_quadrature_status dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
      .prdata_out(prdata), .pha_in(pha), .phb_in(phb), .idx_in(idx), .direction_out(dir), .counter_out(count));
   quad_encoder_model enc (.clk_in(mclk_in), .pha_out(pha), .phb_out(phb), .idx_out(idx));
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
      @(posedge mclk_in);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge mclk_in);
      penable <= 1'b1;
      @(posedge mclk_in);
      while (pready !== 1'b1) @(posedge mclk_in);
      d = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      apb(0, 8'hd4, 0, r1, err); chk("flags reset", 32'h0, r1);
      apb(1, 8'hd4, 32'hffffffff, r1, err); apb(0, 8'hd4, 0, r1, err); chk("flags ro", 32'h0, r1);
      apb(0, 8'h50, 0, r1, err); chk("unmapped err", 32'h1, {31'h0, err}); chk("unmapped data", 32'h0, r1);
      apb(0, 8'he0, 32'h0, r1, err);
      chk("limit reset", 32'h8, r1);
      apb(1, 8'h94, 32'h12345678, r1, err);
      apb(0, 8'h8c, 32'h0, r1, err);
      chk("compare a", 32'h12345678, r1);
      apb(1, 8'ha4, 32'h5, r1, err);
      apb(1, 8'ha8, 32'h4, r1, err);
      apb(0, 8'hac, 32'h0, r1, err);
      chk("irq mask", 32'h1, r1);
      $display("test registers done");
      repeat (4) enc.move(2'h1);
      repeat (6) @(posedge mclk_in);
      apb(0, 8'hd4, 0, r1, err); chk("forward flags", 32'h0, r1);
      chk("count forward", 32'h4, count);
      chk("dir forward", 32'h0, {31'h0, dir});
      enc.move(2'h3); dir_exp = 1'b1;
      repeat (6) @(posedge mclk_in);
      apb(0, 8'hd4, 0, r1, err); chk("reverse flags", 32'h102, r1);
      chk("dir reverse", 32'h1, {31'h0, dir});
      chk("count reverse", 32'h3, count);
      apb(0, 8'hd4, 0, r1, err); chk("reverse cleared", 32'h100, r1);
      $display("test direction done");
      for (int k = 0; k < 8; k++) begin
         enc.move(dir_exp ? 2'h1 : 2'h3);
         dir_exp = ~dir_exp;
         repeat (k) @(posedge mclk_in);
         apb(0, 8'hd4, 0, r1, err); apb(0, 8'hd4, 0, r2, err);
         chk("reversal kept", 32'h2, (r1 | r2) & 32'h2);
         chk("direction", {23'h0, dir_exp, 8'h0}, r2 & 32'h100);
      end
      $display("test read race done");
      apb(0, 8'h90, 32'h0, r1, err);
      chk("count read", 32'h3, r1);
      apb(1, 8'hc0, 32'h1, r1, err);
      apb(0, 8'h90, 32'h0, r1, err);
      chk("count cleared", 32'h0, r1);
      enc.pulse_index();
      repeat (6) @(posedge mclk_in);
      apb(0, 8'hd4, 32'h0, r1, err);
      chk("index flag", 32'h1, r1 & 32'h1);
      apb(0, 8'hd4, 32'h0, r1, err);
      chk("index cleared", 32'h0, r1 & 32'h1);
      $display("test counter and index done");
      enc.move(2'h2);
      repeat (6) @(posedge mclk_in);
      apb(0, 8'hd4, 0, r1, err); chk("phase fault", 32'h4, r1 & 32'h4);
      apb(0, 8'hd4, 0, r1, err); chk("phase fault cleared", 32'h0, r1 & 32'h4);
      $display("test phase fault done");
      apb(1, 8'he0, 32'h1, r1, err);
      repeat (300) @(posedge mclk_in);
      apb(0, 8'hd4, 0, r1, err); chk("missing pulse", 32'h8, r1 & 32'h8);
      apb(1, 8'he0, 32'h0, r1, err);
      apb(0, 8'hd4, 0, r1, err); apb(0, 8'hd4, 0, r1, err); chk("missing cleared", 32'h0, r1 & 32'h8);
      $display("test missing pulse done");
      summarize();
   end
   initial begin
      repeat (3000) @(posedge mclk_in);
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
